// *** rtl/tad_cfg.svh ***
// Constants for the test and addressing-mode decode core.
// Functional notes
// - Test checks A, X or memory; sets N,Z only
// - Test opcodes 3D,4D,5D,6D,7D,9E 6D
// - Short indexed address is H:X plus byte
// - Long indexed: high then low offset byte
// - Stack short address is SP plus byte
// - Stack long address is SP plus two bytes
// - Post-increment indexed uses H:X then increments
// - Offset post-increment uses H:X+byte, then increments
// - Direct-to-indexed move, then H:X increments
// - Indexed-to-direct move, then H:X increments
// - Immediate byte written to direct address
// - Bit branch: direct address, signed offset
// - Full address: high byte then low byte
`ifndef TAD_CFG_SVH
`define TAD_CFG_SVH
// ****************************************
// Opcodes
// ****************************************
`define TAD_OP_PREFIX 8'h9E
`define TAD_OP_ZN_DIR 8'h3D
`define TAD_OP_ZN_A 8'h4D
`define TAD_OP_ZN_X 8'h5D
`define TAD_OP_ZN_IXS 8'h6D
`define TAD_OP_ZN_IX 8'h7D
`define TAD_OP_ZN_SPS 8'h6D
`define TAD_OP_LDA_FULL 8'hC6
`define TAD_OP_LDA_IXL 8'hD6
`define TAD_OP_LDA_SPS 8'hE6
`define TAD_OP_LDA_SPL 8'hD6
`define TAD_OP_MOV_DIXP 8'h5E
`define TAD_OP_MOV_IMMDIR 8'h6E
`define TAD_OP_MOV_IXPD 8'h7E
`define TAD_OP_CBEQ_IX1P 8'h61
`define TAD_OP_CBEQ_IXP 8'h71
`define TAD_OP_BIT_HI 4'h0
// ****************************************
// Reset values and widths
// ****************************************
`define TAD_PC_RST 16'h0000
`define TAD_SP_RST 16'h00FF
`define TAD_BYTE_ZERO 8'h00
`define TAD_ONE16 16'h0001
`endif

// *** rtl/tad_core.sv ***
// Instruction sequencer for the test family and operand addressing modes.
`timescale 1ns/1ps
`include "tad_cfg.svh"
module tad_core import tad_pkg::*; #(
  parameter logic [15:0] RESET_PC = `TAD_PC_RST
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  // Memory port
  output tad_bus_t mem_out,
  input wire logic mem_ready,
  input wire logic [7:0] mem_rdata,
  // Status
  output tad_regs_t regs_out,
  output logic instr_done,
  output logic illegal_op
);

  // ****************************************
  // Decoder
  // ****************************************
  // Maps prefix flag and opcode to operation, mode and operand byte count
  function automatic tad_dec_t tad_decode(input logic pfx, input logic [7:0] op);
    tad_dec_t d;
    d = '{opk: OPK_ILL, mode: MD_INH, nbytes: 2'd0};
    if (pfx) begin
      // Prefixed page: only stack-relative forms exist here
      unique case (op)
        `TAD_OP_ZN_SPS: d = '{opk: OPK_ZNCHK, mode: MD_SPS, nbytes: 2'd1};
        `TAD_OP_LDA_SPS: d = '{opk: OPK_LDA, mode: MD_SPS, nbytes: 2'd1};
        `TAD_OP_LDA_SPL: d = '{opk: OPK_LDA, mode: MD_SPL, nbytes: 2'd2};
        default: d.opk = OPK_ILL;
      endcase
    end else if (op[7:4] == `TAD_OP_BIT_HI) begin
      d = '{opk: OPK_BRBIT, mode: MD_DIR, nbytes: 2'd2};
    end else begin
      unique case (op)
        `TAD_OP_ZN_DIR: d = '{opk: OPK_ZNCHK, mode: MD_DIR, nbytes: 2'd1};
        `TAD_OP_ZN_A: d = '{opk: OPK_ZNA, mode: MD_INH, nbytes: 2'd0};
        `TAD_OP_ZN_X: d = '{opk: OPK_ZNX, mode: MD_INH, nbytes: 2'd0};
        `TAD_OP_ZN_IXS: d = '{opk: OPK_ZNCHK, mode: MD_IXS, nbytes: 2'd1};
        `TAD_OP_ZN_IX: d = '{opk: OPK_ZNCHK, mode: MD_IX, nbytes: 2'd0};
        `TAD_OP_LDA_FULL: d = '{opk: OPK_LDA, mode: MD_FULL, nbytes: 2'd2};
        `TAD_OP_LDA_IXL: d = '{opk: OPK_LDA, mode: MD_IXL, nbytes: 2'd2};
        `TAD_OP_MOV_DIXP: d = '{opk: OPK_MOV, mode: MD_DIXP, nbytes: 2'd1};
        `TAD_OP_MOV_IMMDIR: d = '{opk: OPK_MOV, mode: MD_IMMDIR, nbytes: 2'd2};
        `TAD_OP_MOV_IXPD: d = '{opk: OPK_MOV, mode: MD_IXPD, nbytes: 2'd1};
        `TAD_OP_CBEQ_IX1P: d = '{opk: OPK_CBEQ, mode: MD_IX1P, nbytes: 2'd2};
        `TAD_OP_CBEQ_IXP: d = '{opk: OPK_CBEQ, mode: MD_IXP, nbytes: 2'd1};
        default: d.opk = OPK_ILL; // Rest of the map lives elsewhere
      endcase
    end
    return d;
  endfunction : tad_decode

  // ****************************************
  // State
  // ****************************************
  tad_state_t st_q, st_d; // Sequencer state
  tad_regs_t r_q, r_d; // Programmer registers
  tad_bus_t bus_q, bus_d; // Registered memory request
  logic [7:0] opc_q, opc_d; // Current opcode
  logic pfx_q, pfx_d; // Prefix byte seen
  logic [7:0] b1_q, b1_d; // First operand byte
  logic [7:0] b2_q, b2_d; // Second operand byte
  logic [1:0] cnt_q, cnt_d; // Operand bytes fetched
  logic [7:0] dat_q, dat_d; // Operand data
  logic ill_q, ill_d; // Illegal opcode pulse
  logic done_q, done_d; // Instruction retired pulse

  // ****************************************
  // Address arithmetic
  // ****************************************
  tad_dec_t dec; // Decode of current opcode
  logic [15:0] hx; // Index pair
  logic [15:0] dir_a1; // Direct page address from byte 1
  logic [15:0] dir_a2; // Direct page address from byte 2
  logic [15:0] off16; // Long offset, high byte first
  logic [15:0] ea_src; // Operand read address
  logic [15:0] ea_dst; // Move destination address
  logic [7:0] rel; // Branch displacement
  logic [15:0] pc_br; // Branch target
  logic bit_val; // Tested bit of operand

  // Effective addresses for every mode
  always_comb begin
    dec = tad_decode(pfx_q, opc_q);
    hx = {r_q.h, r_q.x};
    dir_a1 = {`TAD_BYTE_ZERO, b1_q};
    dir_a2 = {`TAD_BYTE_ZERO, b2_q};
    off16 = {b1_q, b2_q};
    ea_src = hx;
    ea_dst = hx;
    rel = b2_q;
    unique case (dec.mode)
      MD_DIR: ea_src = dir_a1;
      MD_FULL: ea_src = off16;
      MD_IX: ea_src = hx;
      MD_IXS: ea_src = hx + dir_a1;
      MD_IXL: ea_src = hx + off16;
      MD_SPS: ea_src = r_q.sp + dir_a1;
      MD_SPL: ea_src = r_q.sp + off16;
      MD_IXP: begin
        ea_src = hx;
        rel = b1_q;
      end
      MD_IX1P: ea_src = hx + dir_a1;
      MD_DIXP: begin
        ea_src = dir_a1;
        ea_dst = hx;
      end
      MD_IXPD: begin
        ea_src = hx;
        ea_dst = dir_a1;
      end
      MD_IMMDIR: ea_dst = dir_a2;
      MD_INH: ea_src = hx;
    endcase
    pc_br = r_q.pc + {{8{rel[7]}}, rel};
    bit_val = dat_q[opc_q[3:1]];
  end

  // ****************************************
  // Sequencer next state
  // ****************************************
  // Each memory access: raise request, wait for ready, then act
  always_comb begin
    st_d = st_q;
    r_d = r_q;
    bus_d = bus_q;
    opc_d = opc_q;
    pfx_d = pfx_q;
    b1_d = b1_q;
    b2_d = b2_q;
    cnt_d = cnt_q;
    dat_d = dat_q;
    ill_d = 1'b0;
    done_d = 1'b0;
    unique case (st_q)
      // Opcode fetch at the program counter
      ST_FETCH: begin
        if (!bus_q.req) begin
          bus_d = '{req: 1'b1, we: 1'b0, addr: r_q.pc, wdata: `TAD_BYTE_ZERO};
        end else if (mem_ready) begin
          bus_d.req = 1'b0;
          opc_d = mem_rdata;
          r_d.pc = r_q.pc + `TAD_ONE16;
          st_d = ST_DEC;
        end
      end
      // Classify; prefix byte loops back for the real opcode
      ST_DEC: begin
        cnt_d = 2'd0;
        if (!pfx_q && opc_q == `TAD_OP_PREFIX) begin
          pfx_d = 1'b1;
          st_d = ST_FETCH;
        end else if (dec.opk == OPK_ILL) begin
          pfx_d = 1'b0; // No state touched besides the flag
          ill_d = 1'b1;
          st_d = ST_FETCH;
        end else if (dec.nbytes != 2'd0) begin
          st_d = ST_OPND;
        end else if (dec.opk == OPK_ZNA || dec.opk == OPK_ZNX) begin
          st_d = ST_EXEC;
        end else begin
          st_d = ST_READ;
        end
      end
      // Operand bytes in stream order
      ST_OPND: begin
        if (!bus_q.req) begin
          bus_d = '{req: 1'b1, we: 1'b0, addr: r_q.pc, wdata: `TAD_BYTE_ZERO};
        end else if (mem_ready) begin
          bus_d.req = 1'b0;
          r_d.pc = r_q.pc + `TAD_ONE16;
          cnt_d = cnt_q + 2'd1;
          if (cnt_q == 2'd0) begin
            b1_d = mem_rdata; // High byte, sole byte, immediate data, direct address or index offset
          end else begin
            b2_d = mem_rdata; // Low byte, branch offset or move destination address
          end
          if (cnt_q + 2'd1 == dec.nbytes) begin
            if (dec.mode == MD_IMMDIR) begin
              dat_d = (cnt_q == 2'd0) ? mem_rdata : b1_q;
              st_d = ST_WRITE;
            end else begin
              st_d = ST_READ;
            end
          end
        end
      end
      // Operand read at the effective address
      ST_READ: begin
        if (!bus_q.req) begin
          bus_d = '{req: 1'b1, we: 1'b0, addr: ea_src, wdata: `TAD_BYTE_ZERO};
        end else if (mem_ready) begin
          bus_d.req = 1'b0;
          dat_d = mem_rdata;
          st_d = (dec.opk == OPK_MOV) ? ST_WRITE : ST_EXEC;
        end
      end
      // Move destination write, then post-increment where the mode asks
      ST_WRITE: begin
        if (!bus_q.req) begin
          bus_d = '{req: 1'b1, we: 1'b1, addr: ea_dst, wdata: dat_q};
        end else if (mem_ready) begin
          bus_d.req = 1'b0;
          bus_d.we = 1'b0;
          r_d.n = dat_q[7];
          r_d.z = (dat_q == `TAD_BYTE_ZERO);
          if (dec.mode == MD_DIXP || dec.mode == MD_IXPD) begin
            {r_d.h, r_d.x} = hx + `TAD_ONE16;
          end
          pfx_d = 1'b0;
          done_d = 1'b1;
          st_d = ST_FETCH;
        end
      end
      // Register-only completion
      ST_EXEC: begin
        unique case (dec.opk)
          OPK_ZNA: begin
            r_d.n = r_q.a[7];
            r_d.z = (r_q.a == `TAD_BYTE_ZERO);
          end
          OPK_ZNX: begin
            r_d.n = r_q.x[7];
            r_d.z = (r_q.x == `TAD_BYTE_ZERO);
          end
          OPK_ZNCHK: begin
            r_d.n = dat_q[7];
            r_d.z = (dat_q == `TAD_BYTE_ZERO);
          end
          OPK_LDA: begin
            r_d.a = dat_q;
            r_d.n = dat_q[7];
            r_d.z = (dat_q == `TAD_BYTE_ZERO);
          end
          OPK_CBEQ: begin
            {r_d.h, r_d.x} = hx + `TAD_ONE16;
            if (r_q.a == dat_q) begin
              r_d.pc = pc_br;
            end
          end
          OPK_BRBIT: begin
            r_d.c = bit_val;
            // Even opcodes branch on set, odd ones on clear
            if (bit_val != opc_q[0]) begin
              r_d.pc = pc_br;
            end
          end
          default: begin
            r_d = r_q; // Not reachable from decode
          end
        endcase
        pfx_d = 1'b0;
        done_d = 1'b1;
        st_d = ST_FETCH;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  // Synchronous reset; enable low freezes everything
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= ST_FETCH;
      r_q <= '{a: `TAD_BYTE_ZERO, h: `TAD_BYTE_ZERO, x: `TAD_BYTE_ZERO,
               sp: `TAD_SP_RST, pc: RESET_PC, n: 1'b0, z: 1'b0, c: 1'b0};
      bus_q <= '{req: 1'b0, we: 1'b0, addr: `TAD_PC_RST, wdata: `TAD_BYTE_ZERO};
      opc_q <= `TAD_BYTE_ZERO;
      pfx_q <= 1'b0;
      b1_q <= `TAD_BYTE_ZERO;
      b2_q <= `TAD_BYTE_ZERO;
      cnt_q <= 2'd0;
      dat_q <= `TAD_BYTE_ZERO;
      ill_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      r_q <= r_d;
      bus_q <= bus_d;
      opc_q <= opc_d;
      pfx_q <= pfx_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      cnt_q <= cnt_d;
      dat_q <= dat_d;
      ill_q <= ill_d;
      done_q <= done_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // All straight from flip-flops
  assign mem_out = bus_q;
  assign regs_out = r_q;
  assign instr_done = done_q;
  assign illegal_op = ill_q;

endmodule : tad_core

// *** rtl/tad_pkg.sv ***
// Types shared by the test and addressing-mode decode core.
package tad_pkg;
  // Operation kinds
  typedef enum logic [2:0] {OPK_ZNCHK, OPK_ZNA, OPK_ZNX, OPK_LDA, OPK_MOV, OPK_CBEQ,
                            OPK_BRBIT, OPK_ILL} tad_opk_t;
  // Addressing modes
  typedef enum logic [3:0] {MD_INH, MD_DIR, MD_FULL, MD_IX, MD_IXS, MD_IXL, MD_SPS, MD_SPL,
                            MD_IXP, MD_IX1P, MD_DIXP, MD_IXPD, MD_IMMDIR} tad_mode_t;
  // Sequencer states
  typedef enum logic [2:0] {ST_FETCH, ST_DEC, ST_OPND, ST_READ, ST_WRITE, ST_EXEC} tad_state_t;
  // Decoded instruction
  typedef struct packed {
    tad_opk_t opk;
    tad_mode_t mode;
    logic [1:0] nbytes;
  } tad_dec_t;
  // Memory request
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } tad_bus_t;
  // Programmer-visible registers
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] h;
    logic [7:0] x;
    logic [15:0] sp;
    logic [15:0] pc;
    logic n;
    logic z;
    logic c;
  } tad_regs_t;
endpackage : tad_pkg

// *** test/tad_core_checker.sv ***
// Port-level assertions for the test and addressing-mode decode core.
`timescale 1ns/1ps
module tad_core_checker import tad_pkg::*; #(
  parameter logic [15:0] RESET_PC = 16'h0000
) (
  // Clock and control
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  // Memory port
  input tad_bus_t mem_out,
  input wire logic mem_ready,
  input wire logic [7:0] mem_rdata,
  // Status
  input tad_regs_t regs_out,
  input wire logic instr_done,
  input wire logic illegal_op
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Reset has no disable, it is the cause here
  a_reset_vals: assert property (disable iff (1'b0) srst && ce |=> !mem_out.req &&
    regs_out.pc == RESET_PC && regs_out.sp == 16'h00FF && !instr_done && !illegal_op)
    else $error("reset values wrong");
  a_boot_fetch: assert property ($fell(srst) && ce |=> mem_out.req &&
    mem_out.addr == RESET_PC) else $error("first fetch not at reset pc");
  // A request must not wobble while the memory stalls
  a_req_hold: assert property (mem_out.req && !mem_ready |=> mem_out.req &&
    $stable(mem_out.addr) && $stable(mem_out.we) && $stable(mem_out.wdata))
    else $error("request changed before acceptance");
  a_req_gap: assert property (mem_out.req && mem_ready && ce |=> !mem_out.req)
    else $error("no idle cycle after accepted request");
  a_done_pulse: assert property (instr_done && ce |=> !instr_done)
    else $error("done pulse too long");
  a_pulse_excl: assert property (!(instr_done && illegal_op))
    else $error("done and illegal together");
  // Only post-increment forms touch the index pair, always by one
  a_hx_step: assert property ($changed({regs_out.h, regs_out.x}) |->
    {regs_out.h, regs_out.x} == $past({regs_out.h, regs_out.x}) + 16'h0001)
    else $error("index pair moved by other than one");
  a_ill_noop: assert property (illegal_op |-> $stable(regs_out.a) &&
    $stable({regs_out.h, regs_out.x})) else $error("illegal opcode changed state");
  a_sp_fixed: assert property (regs_out.sp == 16'h00FF)
    else $error("stack pointer moved");
  // Retire pulse and fetch request are one cycle apart: the fetch is raised next
  a_done_fetch: assert property (instr_done && ce |=> mem_out.req &&
    mem_out.addr == regs_out.pc) else $error("next fetch not at pc");
endmodule : tad_core_checker
bind tad_core tad_core_checker #(.RESET_PC(RESET_PC)) tad_core_checker_i (
  .sys_clk(sys_clk), .srst(srst), .ce(ce), .mem_out(mem_out), .mem_ready(mem_ready),
  .mem_rdata(mem_rdata), .regs_out(regs_out), .instr_done(instr_done),
  .illegal_op(illegal_op));

// *** test/test_test_and_addressing_mode_decode.sv ***
// Self-checking bench running one program through the decode core.
`timescale 1ns/1ps
module test_test_and_addressing_mode_decode import tad_pkg::*;;
  // Clock, control and memory port
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic mem_ready = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  tad_bus_t mem_out;
  tad_regs_t regs_out;
  logic instr_done;
  logic illegal_op;
  // Bench state
  logic [7:0] mem [0:65535];
  logic slow = 1'b0;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  tad_regs_t snap_r;
  tad_bus_t snap_m;
  // Program image at 8000, gaps are never executed
  logic [7:0] prog [0:69] = '{
    8'hC6, 8'h10, 8'h00, 8'h4D, 8'h5D, 8'h3D, 8'h20, 8'h6E, 8'h7F, 8'h40, 8'h5E, 8'h40,
    8'h7E, 8'h50, 8'h7D, 8'h6D, 8'h03, 8'hD6, 8'h01, 8'h00, 8'h9E, 8'h6D, 8'h01, 8'h9E,
    8'hE6, 8'h02, 8'h9E, 8'hD6, 8'h01, 8'h00, 8'h71, 8'h10, 8'h61, 8'h04, 8'h10, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h60, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h61, 8'h7F, 8'h01, 8'h60, 8'hF0, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h9E, 8'h4D, 8'h4D};

  tad_core #(.RESET_PC(16'h8000)) tad_core_i (.sys_clk(sys_clk), .srst(srst), .ce(ce),
    .mem_out(mem_out), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .regs_out(regs_out), .instr_done(instr_done), .illegal_op(illegal_op));

  // 100 ns clock
  always #50 sys_clk = ~sys_clk;
  // Memory answers at the falling edge; a stalled answer shows inverted data
  always @(negedge sys_clk) begin
    mem_ready <= !slow || (cycles % 3 == 0);
    mem_rdata <= (!slow || (cycles % 3 == 0)) ? mem[mem_out.addr] : ~mem[mem_out.addr];
  end
  // Writes land only when the core's request is accepted
  always @(posedge sys_clk) begin
    if (mem_out.req && mem_out.we && mem_ready && ce) begin
      mem[mem_out.addr] <= mem_out.wdata;
    end
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Wait for one retirement or illegal pulse, then judge pc, A and N,Z
  task step(input logic ill, input logic [1:0] ck, input logic [15:0] pc,
            input logic [7:0] a, input logic [1:0] nz);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (instr_done !== 1'b1 && illegal_op !== 1'b1 && k < 300) begin
      @(negedge sys_clk);
      k++;
    end
    chk("kind", {14'h0, ill, 1'b1}, {14'h0, illegal_op, instr_done | illegal_op});
    if (ck[0]) begin
      chk("pc", pc, regs_out.pc);
      chk("a", {8'h00, a}, {8'h00, regs_out.a});
    end
    if (ck[1]) begin
      chk("nz", {14'h0, nz}, {14'h0, regs_out.n, regs_out.z});
    end
  endtask : step
  task end_sim();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // ****************************************
  // Scenarios
  // ****************************************
  task t_test_family();
    step(1'b0, 2'h3, 16'h8003, 8'h80, 2'h2);
    step(1'b0, 2'h3, 16'h8004, 8'h80, 2'h2);
    step(1'b0, 2'h3, 16'h8005, 8'h80, 2'h1);
    step(1'b0, 2'h3, 16'h8007, 8'h80, 2'h2);
  endtask : t_test_family
  // Moves under a stalling memory
  task t_moves();
    slow = 1'b1;
    step(1'b0, 2'h3, 16'h800A, 8'h80, 2'h0);
    chk("imm dest", 16'h007F, {8'h00, mem[16'h0040]});
    step(1'b0, 2'h3, 16'h800C, 8'h80, 2'h0);
    chk("dix dest", 16'h007F, {8'h00, mem[16'h0000]});
    chk("hx", 16'h0001, {regs_out.h, regs_out.x});
    step(1'b0, 2'h3, 16'h800E, 8'h80, 2'h1);
    chk("ixd dest", 16'h0000, {8'h00, mem[16'h0050]});
    chk("hx", 16'h0002, {regs_out.h, regs_out.x});
    slow = 1'b0;
  endtask : t_moves
  task t_index();
    step(1'b0, 2'h3, 16'h800F, 8'h80, 2'h2);
    step(1'b0, 2'h3, 16'h8011, 8'h80, 2'h1);
    step(1'b0, 2'h3, 16'h8014, 8'h42, 2'h0);
  endtask : t_index
  // Stack forms, with a clock-enable freeze inside the first fetch
  task t_stack();
    @(negedge sys_clk);
    ce = 1'b0;
    snap_r = regs_out;
    snap_m = mem_out;
    repeat (4) @(negedge sys_clk);
    chk("frozen", 16'h0001, {15'h0, regs_out === snap_r && mem_out === snap_m});
    ce = 1'b1;
    step(1'b0, 2'h3, 16'h8017, 8'h42, 2'h2);
    step(1'b0, 2'h3, 16'h801A, 8'h00, 2'h1);
    step(1'b0, 2'h3, 16'h801E, 8'h01, 2'h0);
  endtask : t_stack
  task t_branches();
    step(1'b0, 2'h1, 16'h8020, 8'h01, 2'h0);
    chk("hx", 16'h0003, {regs_out.h, regs_out.x});
    step(1'b0, 2'h1, 16'h8033, 8'h01, 2'h0);
    chk("hx", 16'h0004, {regs_out.h, regs_out.x});
    step(1'b0, 2'h1, 16'h8036, 8'h01, 2'h0);
    chk("c", 16'h0000, {15'h0, regs_out.c});
    step(1'b0, 2'h1, 16'h8029, 8'h01, 2'h0);
    chk("c", 16'h0000, {15'h0, regs_out.c});
    step(1'b0, 2'h1, 16'h8043, 8'h01, 2'h0);
    chk("c", 16'h0001, {15'h0, regs_out.c});
  endtask : t_branches
  // Undefined prefixed opcode, then decoding must resume
  task t_illegal();
    step(1'b1, 2'h0, 16'h0000, 8'h00, 2'h0);
    step(1'b0, 2'h3, 16'h8046, 8'h01, 2'h0);
  endtask : t_illegal

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
    for (int i = 0; i < 70; i++) begin
      mem[16'h8000 + i] = prog[i];
    end
    mem[16'h1000] = 8'h80;
    mem[16'h0020] = 8'hFF;
    mem[16'h0002] = 8'h80;
    mem[16'h0102] = 8'h42;
    mem[16'h0100] = 8'h80;
    mem[16'h01FF] = 8'h01;
    mem[16'h0007] = 8'h01;
    mem[16'h0060] = 8'hFE;
    repeat (6) @(negedge sys_clk);
    srst = 1'b0;
    t_test_family();
    t_moves();
    t_index();
    t_stack();
    t_branches();
    t_illegal();
    end_sim();
  end
endmodule : test_test_and_addressing_mode_decode
